// >>> psrb_pkg.sv
// Package: constants and types for the power sequencer register bank
//------------------------------------------------------------------
// Operation
//------------------------------------------------------------------
// Operation
// - Temperature words read upper byte first; 9-bit value in D15-D7, low bits zero.
// - Leaving lockout clears sensor shutdown bit and starts conversions at once.
// - Conversions repeat continuously while not shut down, every 1 s by default.
// - Writing shutdown 1 stops conversions; writing 0 resumes them.
// - Remote diode open or short makes external temperature read 7FC0h.
// - Status register: D0 busy, D1 diode open, D2 diode short.
// - Revision and maker identification registers are fixed, read only.
// - Common-electrode code maps linearly, 00h -0.50 V to FFh -3.05 V.
// - After lockout the common-electrode code loads from stored value, default 7F.
// - Rail and common-electrode enable bits are ORed with their pins.
// - Setting rail enable starts power-up using t1-t4 held then.
// - Clearing rail enable starts power-down using t5-t8 held then.
// - Common-electrode enable 1 drives output; 0 discharges it to ground.
// - A latching fault latches outputs off, clears enables, sets cause bit.
// - Enable pins never change stored enable register bits.
// - Fault bits stay set until logic supply power cycle, not cleared by read.
// - Fault layout: gate, boost, inverting, negative gate, shorts, thermal, power good.
// - Power good sets when rails are up, clears on power-down or fault.
// - Diode open or short only reports status, never latches outputs off.
// - Boost setting loads 0Ah after lockout when feedback pin grounded; keeps writes.
// - Boost code D3-D0 gives 5 V at 00h to 17 V at 0Ch in 1 V steps.
// - Conversion rate resets to 04h; only 3 low bits choose the interval.
package psrb_pkg;

	//------------------------------------------------------------------
	// Register pointers
	//------------------------------------------------------------------
	localparam logic [7:0] PSRB_EXT_TEMP = 8'h00;
	localparam logic [7:0] PSRB_CONFIG = 8'h01;
	localparam logic [7:0] PSRB_INT_TEMP = 8'h04;
	localparam logic [7:0] PSRB_STATUS = 8'h05;
	localparam logic [7:0] PSRB_REVISION = 8'h06;
	localparam logic [7:0] PSRB_MAKER_ID = 8'h07;
	localparam logic [7:0] PSRB_CE_CODE = 8'h08;
	localparam logic [7:0] PSRB_ENABLE = 8'h09;
	localparam logic [7:0] PSRB_FAULT = 8'h0A;
	localparam logic [7:0] PSRB_BOOST = 8'h0B;
	localparam logic [7:0] PSRB_CONV_RATE = 8'h0F;

	//------------------------------------------------------------------
	// Reset values and fixed words
	//------------------------------------------------------------------
	localparam logic [7:0] PSRB_CE_CODE_DEFAULT = 8'h7F;
	localparam logic [7:0] PSRB_BOOST_DEFAULT = 8'h0A;
	localparam logic [7:0] PSRB_CONV_RATE_RESET = 8'h04;
	localparam logic [15:0] PSRB_DIODE_FAULT_WORD = 16'h7FC0;
	// Identity values are arbitrary
	localparam logic [7:0] PSRB_REVISION_CODE = 8'h11;
	localparam logic [7:0] PSRB_MAKER_CODE = 8'h22;
	localparam logic [6:0] PSRB_DEV_ADDR = 7'h48;

	//------------------------------------------------------------------
	// Field positions
	//------------------------------------------------------------------
	localparam int PSRB_SHUTDOWN_BIT = 0;
	localparam int PSRB_RAIL_EN_BIT = 0;
	localparam int PSRB_CE_EN_BIT = 1;
	localparam int PSRB_POWER_GOOD_BIT = 7;
	localparam int PSRB_FAULT_CAUSES = 7;

	//------------------------------------------------------------------
	// Timing
	//------------------------------------------------------------------
	localparam int PSRB_CLK_HZ = 100_000_000;
	localparam int PSRB_SLOWEST_PERIOD_S = 16;
	localparam int PSRB_CONVERSION_US = 1000;
	localparam int PSRB_CONVERSION_CYC = PSRB_CONVERSION_US * (PSRB_CLK_HZ / 1_000_000);
	localparam int PSRB_EIGHTH_S_CYC = PSRB_CLK_HZ / 8;

	typedef enum logic [2:0] {
		BUS_IDLE, BUS_ADDR, BUS_ACK, BUS_WRITE, BUS_READ, BUS_READ_ACK, BUS_SKIP
	} psrb_bus_state_type;

	typedef struct packed {
		logic open;
		logic short_circuit;
		logic busy;
	} psrb_diode_type;

endpackage : psrb_pkg

// >>> psrb_bank.sv
// Register bank behind the two-wire serial port
`timescale 1ns/1ns
module psrb_bank
	import psrb_pkg::*;
#(
	parameter int SECOND_CYCLES = PSRB_CLK_HZ,
	parameter int CONVERSION_CYCLES = PSRB_CONVERSION_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Enable pins and straps
	input wire logic rail_enable_pin,
	input wire logic common_electrode_enable_pin,
	input wire logic boost_feedback_pin_grounded,
	input wire logic [7:0] stored_ce_code,
	// Sensor front end
	input wire logic [8:0] ext_temp_sample,
	input wire logic [8:0] int_temp_sample,
	input wire logic diode_open,
	input wire logic diode_short,
	// Power stage
	input wire logic [6:0] fault_causes,
	input wire logic rails_in_regulation,
	output logic rail_sequence_on,
	output logic common_electrode_output_enable,
	output logic outputs_latched_off,
	output logic conversion_start,
	output logic [7:0] common_electrode_voltage_code,
	output logic [3:0] boost_rail_code
);

	//------------------------------------------------------------------
	// Reset release and pin synchronisers
	//------------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_ok;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_ok = rst_sync_q[1];

	localparam int NSYNC = 13;
	localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h0003; // Bus lines idle high, so release shows no false edge
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_s1_q;
	logic [NSYNC-1:0] pin_s2_q;
	assign pin_raw = {fault_causes, diode_short, diode_open, common_electrode_enable_pin,
		rail_enable_pin, sda_in, scl_in};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_ok) begin
				if (!rst_ok) begin
					pin_s1_q[gi] <= SYNC_IDLE[gi];
					pin_s2_q[gi] <= SYNC_IDLE[gi];
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate

	logic scl_s, sda_s, en_pin_s, cen_pin_s;
	psrb_diode_type diode_s;
	logic [6:0] causes_s;
	assign scl_s = pin_s2_q[0];
	assign sda_s = pin_s2_q[1];
	assign en_pin_s = pin_s2_q[2];
	assign cen_pin_s = pin_s2_q[3];
	assign diode_s.open = pin_s2_q[4];
	assign diode_s.short_circuit = pin_s2_q[5];
	assign causes_s = pin_s2_q[12:6];

	logic scl_prev_q, sda_prev_q;
	always_ff @(posedge ref_clk or negedge rst_ok) begin
		if (!rst_ok) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end
	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

	//------------------------------------------------------------------
	// Register state
	//------------------------------------------------------------------
	logic shutdown_q, shutdown_d;
	logic [7:0] ce_code_q, ce_code_d;
	logic rail_en_q, rail_en_d, cen_q, cen_d;
	logic [7:0] fault_q, fault_d;
	logic [3:0] boost_q, boost_d;
	logic [7:0] rate_q, rate_d;
	logic [8:0] ext_temp_q, ext_temp_d, int_temp_q, int_temp_d;
	logic loaded_q, loaded_d;
	logic wr_strobe;
	logic [7:0] wr_ptr, wr_data;

	always_comb begin
		shutdown_d = shutdown_q;
		ce_code_d = ce_code_q;
		rail_en_d = rail_en_q;
		cen_d = cen_q;
		fault_d = fault_q;
		boost_d = boost_q;
		rate_d = rate_q;
		loaded_d = 1'b1;
		if (!loaded_q) begin
			shutdown_d = 1'b0;
			ce_code_d = stored_ce_code;
			if (boost_feedback_pin_grounded)
				boost_d = PSRB_BOOST_DEFAULT[3:0];
		end
		if (wr_strobe) begin
			case (wr_ptr)
				PSRB_CONFIG: shutdown_d = wr_data[PSRB_SHUTDOWN_BIT];
				PSRB_CE_CODE: ce_code_d = wr_data;
				PSRB_ENABLE: begin
					rail_en_d = wr_data[PSRB_RAIL_EN_BIT];
					cen_d = wr_data[PSRB_CE_EN_BIT];
				end
				PSRB_BOOST: boost_d = wr_data[3:0];
				PSRB_CONV_RATE: rate_d = wr_data;
				default: ;
			endcase
		end
		// Sticky causes; only reset clears them
		fault_d[PSRB_FAULT_CAUSES-1:0] = fault_q[PSRB_FAULT_CAUSES-1:0] | causes_s;
		if (causes_s != 7'h00) begin
			rail_en_d = 1'b0;
			cen_d = 1'b0;
		end
		// Power good follows rails but drops on power-down or any fault
		fault_d[PSRB_POWER_GOOD_BIT] = rails_in_regulation && (rail_en_q || en_pin_s)
			&& (fault_d[PSRB_FAULT_CAUSES-1:0] == 7'h00);
	end

	always_ff @(posedge ref_clk or negedge rst_ok) begin
		if (!rst_ok) begin
			shutdown_q <= 1'b1;
			ce_code_q <= PSRB_CE_CODE_DEFAULT;
			rail_en_q <= 1'b0;
			cen_q <= 1'b0;
			fault_q <= 8'h00;
			boost_q <= PSRB_BOOST_DEFAULT[3:0];
			rate_q <= PSRB_CONV_RATE_RESET;
			loaded_q <= 1'b0;
		end else begin
			shutdown_q <= shutdown_d;
			ce_code_q <= ce_code_d;
			rail_en_q <= rail_en_d;
			cen_q <= cen_d;
			fault_q <= fault_d;
			boost_q <= boost_d;
			rate_q <= rate_d;
			loaded_q <= loaded_d;
		end
	end

	// Pins are ORed in here, the rail pin also into power good, never stored back
	assign rail_sequence_on = (rail_en_q || en_pin_s) && !outputs_latched_off;
	assign common_electrode_output_enable = (cen_q || cen_pin_s) && !outputs_latched_off;
	assign outputs_latched_off = fault_q[PSRB_FAULT_CAUSES-1:0] != 7'h00;
	assign common_electrode_voltage_code = ce_code_q;
	assign boost_rail_code = boost_q;

	//------------------------------------------------------------------
	// Conversion timer
	//------------------------------------------------------------------
	logic [31:0] period_cnt_q, period_cnt_d, busy_cnt_q, busy_cnt_d;
	logic [31:0] period_len;
	logic conv_go;
	// Interval is 16 s >> code; upper bits of the rate byte ignored
	assign period_len = (SECOND_CYCLES * PSRB_SLOWEST_PERIOD_S) >> rate_q[2:0];
	always_comb begin
		period_cnt_d = period_cnt_q;
		busy_cnt_d = busy_cnt_q;
		conv_go = 1'b0;
		ext_temp_d = ext_temp_q;
		int_temp_d = int_temp_q;
		if (shutdown_q) begin
			period_cnt_d = 32'h0;
		end else if (period_cnt_q == 32'h0) begin
			conv_go = 1'b1;
			busy_cnt_d = CONVERSION_CYCLES;
			period_cnt_d = period_len - 32'h1;
		end else begin
			period_cnt_d = period_cnt_q - 32'h1;
		end
		if (busy_cnt_q != 32'h0) begin
			busy_cnt_d = busy_cnt_q - 32'h1;
			if (busy_cnt_q == 32'h1) begin
				ext_temp_d = ext_temp_sample;
				int_temp_d = int_temp_sample;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_ok) begin
		if (!rst_ok) begin
			period_cnt_q <= 32'h0;
			busy_cnt_q <= 32'h0;
			ext_temp_q <= 9'h000;
			int_temp_q <= 9'h000;
			conversion_start <= 1'b0;
		end else begin
			period_cnt_q <= period_cnt_d;
			busy_cnt_q <= busy_cnt_d;
			ext_temp_q <= ext_temp_d;
			int_temp_q <= int_temp_d;
			conversion_start <= conv_go;
		end
	end
	assign diode_s.busy = busy_cnt_q != 32'h0;

	//------------------------------------------------------------------
	// Read mux
	//------------------------------------------------------------------
	logic [15:0] rd_word;
	always_comb begin
		rd_word = 16'h0000;
		case (wr_ptr)
			PSRB_EXT_TEMP: rd_word = (diode_s.open || diode_s.short_circuit) ? PSRB_DIODE_FAULT_WORD
				: {ext_temp_q, 7'h00};
			PSRB_INT_TEMP: rd_word = {int_temp_q, 7'h00};
			PSRB_CONFIG: rd_word = {7'h00, shutdown_q, 8'h00};
			PSRB_STATUS: rd_word = {5'h00, diode_s.short_circuit, diode_s.open, diode_s.busy, 8'h00};
			PSRB_REVISION: rd_word = {PSRB_REVISION_CODE, 8'h00};
			PSRB_MAKER_ID: rd_word = {PSRB_MAKER_CODE, 8'h00};
			PSRB_CE_CODE: rd_word = {ce_code_q, 8'h00};
			PSRB_ENABLE: rd_word = {6'h00, cen_q, rail_en_q, 8'h00};
			PSRB_FAULT: rd_word = {fault_q, 8'h00};
			PSRB_BOOST: rd_word = {4'h0, boost_q, 8'h00};
			PSRB_CONV_RATE: rd_word = {rate_q, 8'h00};
			default: rd_word = 16'h0000;
		endcase
	end

	//------------------------------------------------------------------
	// Two-wire slave
	//------------------------------------------------------------------
	psrb_bus_state_type st_q, st_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] byte_q, byte_d;
	logic rw_q, rw_d, drv_q, drv_d;
	logic [15:0] rd_q, rd_d;
	assign wr_ptr = ptr_q;
	assign wr_data = sh_q;

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		bit_d = bit_q;
		byte_d = byte_q;
		rw_d = rw_q;
		drv_d = drv_q;
		rd_d = rd_q;
		wr_strobe = 1'b0;
		if (bus_stop) begin
			st_d = BUS_IDLE;
			drv_d = 1'b0;
		end else if (bus_start) begin
			st_d = BUS_ADDR;
			bit_d = 4'h0;
			byte_d = 2'h0;
			drv_d = 1'b0;
		end else begin
			case (st_q)
				BUS_IDLE: ;
				BUS_ADDR, BUS_WRITE: if (scl_rise) begin
					sh_d = {sh_q[6:0], sda_s};
					bit_d = bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					bit_d = 4'h0;
					if (st_q == BUS_ADDR) begin
						if (sh_q[7:1] == PSRB_DEV_ADDR) begin
							rw_d = sh_q[0];
							drv_d = 1'b1;
							rd_d = rd_word;
							st_d = BUS_ACK;
						end else
							st_d = BUS_SKIP;
					end else begin
						// Pointer byte then data bytes
						if (byte_q == 2'h0)
							ptr_d = sh_q;
						else
							wr_strobe = 1'b1;
						if (byte_q != 2'h3)
							byte_d = byte_q + 2'h1;
						drv_d = 1'b1;
						st_d = BUS_ACK;
					end
				end
				BUS_ACK: if (scl_fall) begin
					if (rw_q) begin
						drv_d = !rd_q[15];
						st_d = BUS_READ;
					end else begin
						drv_d = 1'b0;
						st_d = BUS_WRITE;
					end
				end
				BUS_READ: if (scl_fall) begin
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						drv_d = 1'b0;
						st_d = BUS_READ_ACK;
					end else
						drv_d = !rd_q[4'hE - bit_q];
				end
				BUS_READ_ACK: if (scl_rise) begin
					if (sda_s)
						st_d = BUS_SKIP;
				end else if (scl_fall) begin
					// Low byte of the same captured word follows
					rd_d = {rd_q[7:0], 8'h00};
					bit_d = 4'h0;
					drv_d = !rd_q[7];
					st_d = BUS_READ;
				end
				BUS_SKIP: ;
				default: st_d = BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_ok) begin
		if (!rst_ok) begin
			st_q <= BUS_IDLE;
			sh_q <= 8'h00;
			ptr_q <= PSRB_EXT_TEMP;
			bit_q <= 4'h0;
			byte_q <= 2'h0;
			rw_q <= 1'b0;
			drv_q <= 1'b0;
			rd_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			rw_q <= rw_d;
			drv_q <= drv_d;
			rd_q <= rd_d;
		end
	end

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_n = !drv_q;

endmodule : psrb_bank

// >>> psrb_bank_monitor.sv
// Port assertions for the register bank
`timescale 1ns/1ns
module psrb_bank_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Watched inputs
	input wire logic rail_enable_pin,
	input wire logic common_electrode_enable_pin,
	input wire logic diode_open,
	input wire logic diode_short,
	input wire logic [6:0] fault_causes,
	// Watched outputs
	input wire logic rail_sequence_on,
	input wire logic common_electrode_output_enable,
	input wire logic outputs_latched_off,
	input wire logic conversion_start
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	//------------------------------------------------------------------
	// Sequences
	//------------------------------------------------------------------
	// Two cycles of cause so a glitch is not demanded to latch
	sequence s_fault_held;
		fault_causes != 7'h00 ##1 fault_causes != 7'h00;
	endsequence
	sequence s_quiet_after;
		##1 !conversion_start [*8];
	endsequence
	//------------------------------------------------------------------
	// Properties
	//------------------------------------------------------------------
	AST_FAULT_LATCH: assert property (s_fault_held |-> ##[0:4] outputs_latched_off)
		else $error("fault did not latch outputs off");
	AST_RAIL_OFF: assert property (outputs_latched_off |-> !rail_sequence_on)
		else $error("rails on while latched off");
	AST_CE_OFF: assert property (outputs_latched_off |-> !common_electrode_output_enable)
		else $error("common electrode on while latched off");
	AST_STICKY: assert property (outputs_latched_off |=> outputs_latched_off)
		else $error("fault latch cleared");
	AST_RAIL_PIN: assert property ($rose(rail_enable_pin) && !outputs_latched_off |-> ##[1:4] rail_sequence_on)
		else $error("rail pin not ORed in");
	AST_CE_PIN: assert property ($rose(common_electrode_enable_pin) && !outputs_latched_off
		|-> ##[1:4] common_electrode_output_enable)
		else $error("common electrode pin not ORed in");
	AST_DIODE_ONLY: assert property ((diode_open || diode_short) && fault_causes == 7'h00
		&& !outputs_latched_off |=> !outputs_latched_off)
		else $error("diode fault latched outputs");
	AST_CONV_PULSE: assert property (conversion_start |-> s_quiet_after)
		else $error("conversion start not a lone pulse");
endmodule : psrb_bank_monitor

bind psrb_bank psrb_bank_monitor i_mon (.*);

// >>> psrb_host.sv
// Two-wire bus host model for the register bank
`timescale 1ns/1ns
module psrb_host
	import psrb_pkg::*;
(
	// Device side of the data line
	input wire logic sda_out,
	input wire logic sda_oe_n,
	// Bus lines
	output logic scl,
	output logic sda,
	// Read results
	output logic [15:0] rd_word,
	output logic rd_valid
);
	logic pull_low = 1'b0;
	// Open drain with pull-up: a released line reads high
	assign sda = pull_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);
	initial begin
		scl = 1'b1;
		rd_word = 16'h0000;
		rd_valid = 1'b0;
	end
	// Frames start 1 ns after a clock edge and last a multiple of 5 ns, so no line moves on an edge
	task automatic bit_io(input logic b, output logic r);
		#31 pull_low = !b;
		#32 scl = 1'b1;
		r = sda;
		#62 scl = 1'b0;
	endtask : bit_io
	task automatic do_start();
		#31 pull_low = 1'b0;
		#32 scl = 1'b1;
		#32 pull_low = 1'b1;
		#30 scl = 1'b0;
	endtask : do_start
	// Clock then stands high until the next frame
	task automatic do_stop();
		#31 pull_low = 1'b1;
		#32 scl = 1'b1;
		#32 pull_low = 1'b0;
		#60;
	endtask : do_stop
	task automatic byte_io(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ackd);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], x);
			r[i] = x;
		end
		bit_io(last, x);
		ackd = !x;
	endtask : byte_io
	task automatic write_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		do_start();
		byte_io(a, 1'b1, r, k0);
		byte_io(p, 1'b1, r, k1);
		byte_io(d, 1'b1, r, k2);
		do_stop();
		ok = k0 & k1 & k2;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] p);
		logic [7:0] hi, lo, r;
		logic k;
		do_start();
		byte_io({PSRB_DEV_ADDR, 1'b0}, 1'b1, r, k);
		byte_io(p, 1'b1, r, k);
		do_stop();
		do_start();
		byte_io({PSRB_DEV_ADDR, 1'b1}, 1'b1, r, k);
		byte_io(8'hFF, 1'b0, hi, k);
		byte_io(8'hFF, 1'b1, lo, k);
		do_stop();
		rd_word = {hi, lo};
		rd_valid = 1'b1;
		#1 rd_valid = 1'b0;
	endtask : read_reg
endmodule : psrb_host

// >>> psrb_bank_tb.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
module psrb_bank_tb;
	import psrb_pkg::*;
	localparam int SEC = 1000;
	localparam logic [7:0] ADDR_W = {PSRB_DEV_ADDR, 1'b0};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda, sda_out, sda_oe_n, rail_on, ce_on, latched, conv, rd_valid, ok;
	logic rail_pin = 1'b0, ce_pin = 1'b0, d_open = 1'b0, d_short = 1'b0, in_reg = 1'b0;
	logic [7:0] nv_code = 8'h3C, ce_code, v;
	logic [3:0] boost;
	logic [8:0] ext_t = 9'h000, int_t = 9'h000;
	logic [6:0] fcause = 7'h00;
	logic [15:0] rd_word;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 62654;
	int failures = 0, n_compared = 0, n;
	always #5 ref_clk = ~ref_clk;
	psrb_bank #(.SECOND_CYCLES(SEC), .CONVERSION_CYCLES(20)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.rail_enable_pin(rail_pin), .common_electrode_enable_pin(ce_pin), .boost_feedback_pin_grounded(1'b1),
		.stored_ce_code(nv_code), .ext_temp_sample(ext_t), .int_temp_sample(int_t), .diode_open(d_open),
		.diode_short(d_short), .fault_causes(fcause), .rails_in_regulation(in_reg), .rail_sequence_on(rail_on),
		.common_electrode_output_enable(ce_on), .outputs_latched_off(latched), .conversion_start(conv),
		.common_electrode_voltage_code(ce_code), .boost_rail_code(boost));
	psrb_host i_host (.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda), .rd_word(rd_word),
		.rd_valid(rd_valid));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [15:0] e, input logic [15:0] g, input string k);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, k, g, e);
		end
	endtask : cmp
	task automatic stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : tick
	// Frames start just off a clock edge; the bench resumes on an edge afterwards
	task automatic rd(input logic [7:0] p, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge ref_clk);
		#1;
		i_host.read_reg(p);
		@(posedge ref_clk);
	endtask : rd
	task automatic wr_at(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		i_host.write_reg(a, p, d, ok);
		@(posedge ref_clk);
	endtask : wr_at
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		wr_at(ADDR_W, p, d);
		cmp(16'h0001, {15'h0000, ok}, "ack");
	endtask : wr
	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		nv_code <= 8'(rnd());
		tick(4);
		rst_n <= 1'b1;
		tick(110);
	endtask : do_reset
	task automatic gap(output int c);
		@(posedge ref_clk iff conv === 1'b1);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (conv !== 1'b1 && c < 20000);
	endtask : gap
	// Results appear on the host read strobe, oldest note first
	always @(posedge rd_valid) cmp(exp_q.pop_front(), rd_word, "read");
	initial begin
		#600_000;
		failures++;
		stop_test();
	end
	initial begin
		do_reset();
		cmp(nv_code, ce_code, "port");
		cmp(PSRB_BOOST_DEFAULT[3:0], boost, "port");
		rd(PSRB_CE_CODE, {nv_code, 8'h00});
		rd(PSRB_BOOST, {PSRB_BOOST_DEFAULT, 8'h00});
		rd(PSRB_CONV_RATE, {PSRB_CONV_RATE_RESET, 8'h00});
		rd(PSRB_CONFIG, 16'h0000);
		wr(PSRB_REVISION, 8'hFF);
		rd(PSRB_REVISION, {PSRB_REVISION_CODE, 8'h00});
		rd(PSRB_MAKER_ID, {PSRB_MAKER_CODE, 8'h00});
		wr_at(8'h92, PSRB_CE_CODE, 8'h00);
		cmp(16'h0000, {15'h0000, ok}, "ack");
		rd(PSRB_CE_CODE, {nv_code, 8'h00});
		$display("test reset values done");
		repeat (3) begin
			v = 8'(rnd() % 13);
			wr(PSRB_BOOST, v);
			cmp(v, boost, "port");
			v = 8'(rnd());
			wr(PSRB_CE_CODE, v);
			cmp(v, ce_code, "port");
		end
		$display("test codes done");
		wr(PSRB_CONV_RATE, 8'hF7);
		gap(n);
		cmp(16'((16 * SEC) >> 7), 16'(n), "gap");
		wr(PSRB_CONV_RATE, 8'h06);
		gap(n);
		cmp(16'((16 * SEC) >> 6), 16'(n), "gap");
		ext_t <= 9'(rnd());
		int_t <= 9'(rnd());
		gap(n);
		tick(40);
		rd(PSRB_EXT_TEMP, {ext_t, 7'h00});
		rd(PSRB_INT_TEMP, {int_t, 7'h00});
		wr(PSRB_CONFIG, 8'h01);
		tick(40);
		n = 0;
		repeat (600) @(posedge ref_clk) n += int'(conv === 1'b1);
		cmp(16'h0000, 16'(n), "pulses");
		d_open <= 1'b1;
		tick(10);
		rd(PSRB_EXT_TEMP, PSRB_DIODE_FAULT_WORD);
		rd(PSRB_STATUS, 16'h0200);
		d_open <= 1'b0;
		d_short <= 1'b1;
		tick(10);
		rd(PSRB_STATUS, 16'h0400);
		cmp(16'h0000, latched, "port");
		d_short <= 1'b0;
		wr(PSRB_CONFIG, 8'h00);
		gap(n);
		cmp(16'((16 * SEC) >> 6), 16'(n), "gap");
		$display("test sensor done");
		wr(PSRB_ENABLE, 8'h01);
		cmp(16'h0001, rail_on, "port");
		in_reg <= 1'b1;
		rd(PSRB_FAULT, 16'h8000);
		wr(PSRB_ENABLE, 8'h02);
		cmp(16'h0000, rail_on, "port");
		cmp(16'h0001, ce_on, "port");
		rd(PSRB_FAULT, 16'h0000);
		wr(PSRB_ENABLE, 8'h00);
		cmp(16'h0000, ce_on, "port");
		rail_pin <= 1'b1;
		ce_pin <= 1'b1;
		tick(10);
		cmp(16'h0001, rail_on & ce_on, "port");
		rd(PSRB_ENABLE, 16'h0000);
		rail_pin <= 1'b0;
		ce_pin <= 1'b0;
		$display("test enables done");
		for (int i = 0; i < 7; i++) begin
			do_reset();
			wr(PSRB_ENABLE, 8'h03);
			fcause <= 7'(1 << i);
			tick(8);
			fcause <= 7'h00;
			tick(4);
			cmp(16'h0001, latched & !rail_on & !ce_on, "port");
			rd(PSRB_FAULT, {8'(1 << i), 8'h00});
			rd(PSRB_ENABLE, 16'h0000);
			cmp(16'h0001, latched, "port");
		end
		$display("test faults done");
		stop_test();
	end
endmodule : psrb_bank_tb
